// ===== tlc_link_cfg.sv
// Token link configuration, token hold timing and AXI4-Lite register slave.
//
// Function
// [R1] Local station accepted only 1 to 64; the code rejects 64, since the station must stay below the station limit.
// [R2] Network number accepted only 1 to 254.
// [R3] Hold target cycle time 1 to 100 ms.
// [R4] Hold window is target minus measured cycle.
// [R5] Nothing queued: pass token at once.
// [R6] Target below measured cycle: link data only.
// [R7] Monitoring zero waits forever for reply.
// [R8] Timeout after twice setting seconds, resend once.
// [R9] Search new stations every N token receptions.
// [R10] Baud rate 10, 2 or 4 Mbps.
// [R11] Station limit 16/32/48/64, above own number.
// [R12] Relay enabled forwards foreign messages onto link.
// [R13] Relay destinations are union of two ranges.
// [R14] Both relay ranges zero disables relaying.
// [R15] Restore command loads the default parameter set.
// [R16] Restore also clears link assignment settings.
// [R17] Each interface needs a unique circuit number.
// [R18] Out-of-range writes rejected, old value kept.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`default_nettype none
module tlc_link_cfg
  import tlc_pkg::*;
#(
  parameter int TICK_CYCLES = MS_NS / CLK_NS
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire tlc_link_in_t link_i,
  output tlc_link_out_t link_o,
  output logic irq
);

  typedef enum logic {T_IDLE, T_HOLD} tlc_tok_t;
  typedef enum logic [1:0] {R_IDLE, R_WAIT, R_RETRY} tlc_rsp_t;

  typedef struct packed {
    logic aw_have;
    logic [AW-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    tlc_cfg_t cfg;
    logic [TICK_W-1:0] tick;
    logic [15:0] cyc_run;
    logic [15:0] cyc_cur;
    tlc_tok_t tst;
    logic msg_ok;
    logic [6:0] hold_left;
    logic [9:0] tok_cnt;
    tlc_rsp_t rst;
    logic [RM_W-1:0] resp_ms;
    logic [NST-1:0] status;
    logic [NST-1:0] irq_en;
    logic irq;
    tlc_link_out_t lo;
  } tlc_state_t;

  localparam logic [TICK_W-1:0] TK_LAST = TICK_W'(TICK_CYCLES - 1);

  tlc_state_t q;
  tlc_state_t n;

  function automatic logic [6:0] sta_limit(input logic [1:0] code);
    sta_limit = 7'({1'b0, code, 4'h0}) + STA_STEP;
  endfunction

  function automatic logic in_rng(input logic [7:0] v, input logic [7:0] lo,
                                  input logic [7:0] hi);
    in_rng = (lo != 8'h00) && (v >= lo) && (v <= hi);
  endfunction

  function automatic logic rng_ok(input logic [15:0] v);
    rng_ok = (v == 16'h0000) ||
             (v[7:0] >= NET_MIN && v[15:8] <= NET_MAX && v[7:0] <= v[15:8]);
  endfunction

  // Returns the readback word with the address hit flag on top.
  function automatic logic [32:0] reg_rd(input tlc_state_t s, input logic [AW-1:0] a);
    reg_rd = {1'b1, 32'h0000_0000};
    case (a)
      A_CTRL: reg_rd[CTRL_RELAY] = s.cfg.relay_en;
      A_STATION: reg_rd[6:0] = s.cfg.station;
      A_NETWORK: reg_rd[7:0] = s.cfg.network;
      A_CYC_TGT: reg_rd[6:0] = s.cfg.cyc_tgt;
      A_RESP_MON: reg_rd[7:0] = s.cfg.resp_mon;
      A_SRCH_INT: reg_rd[9:0] = s.cfg.srch_int;
      A_SPEED: reg_rd[1:0] = s.cfg.speed;
      A_MAXSTA: reg_rd[1:0] = s.cfg.maxsta;
      A_RELAY1: reg_rd[15:0] = {s.cfg.r1hi, s.cfg.r1lo};
      A_RELAY2: reg_rd[15:0] = {s.cfg.r2hi, s.cfg.r2lo};
      A_STATUS: reg_rd[NST-1:0] = s.status;
      A_IRQ_EN: reg_rd[NST-1:0] = s.irq_en;
      A_IRQ_CLR: reg_rd[32] = 1'b1;
      A_CYC_CUR: reg_rd[15:0] = s.cyc_cur;
      default: reg_rd[32] = 1'b0;
    endcase
  endfunction

  always_comb
  begin
    logic ms;
    logic ok;
    logic active;
    logic pass;
    logic hit;
    logic [31:0] mask;
    logic [31:0] wv;
    logic [32:0] rv;
    logic [NST-1:0] ev;
    logic [NST-1:0] clr;
    logic [RM_W-1:0] limit;
    ms = 1'b0;
    ok = 1'b0;
    active = 1'b0;
    pass = 1'b0;
    hit = 1'b0;
    mask = 32'h0000_0000;
    wv = 32'h0000_0000;
    rv = 33'h0_0000_0000;
    ev = '0;
    clr = '0;
    limit = '0;
    n = q;
    n.lo.token_pass = 1'b0;
    n.lo.cmd_resend = 1'b0;
    n.lo.search_start = 1'b0;
    n.lo.relay_fwd = 1'b0;
    n.lo.relay_drop = 1'b0;
    n.lo.assign_clear = 1'b0;
    ms = (q.tick == TK_LAST);
    n.tick = ms ? '0 : q.tick + 1'b1;

    if (awvalid && q.awready)
    begin
      n.aw_have = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && q.wready)
    begin
      n.w_have = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end
    if (q.bvalid && bready)
      n.bvalid = 1'b0;
    if (q.aw_have && q.w_have && !q.bvalid)
    begin
      for (int i = 0; i < 4; i++)
        mask[i*8 +: 8] = {8{q.w_strb[i]}};
      rv = reg_rd(q, q.aw_addr);
      wv = (rv[31:0] & ~mask) | (q.w_data & mask);
      ok = 1'b1;
      case (q.aw_addr)
        A_CTRL:
        begin
          n.cfg.relay_en = wv[CTRL_RELAY];
          if (wv[CTRL_RESTORE])
          begin
            // [R15] Load default set.
            n.cfg = CFG_DEF;
            // [R16] Clear link assignment.
            n.lo.assign_clear = 1'b1;
          end
        end
        A_STATION:
          // [R1] [R11] Station bounds check.
          ok = wv[6:0] >= STA_MIN && wv[6:0] <= STA_MAX && wv[31:7] == '0 &&
               wv[6:0] < sta_limit(q.cfg.maxsta);
        A_NETWORK:
          // [R2] Network bounds check.
          ok = wv[7:0] >= NET_MIN && wv[7:0] <= NET_MAX && wv[31:8] == '0;
        A_CYC_TGT:
          // [R3] Target bounds check.
          ok = wv[6:0] >= CYC_MIN && wv[6:0] <= CYC_MAX && wv[31:7] == '0;
        A_RESP_MON:
          ok = wv[31:8] == '0;
        A_SRCH_INT:
          // [R9] Interval bounds check.
          ok = wv[9:0] >= SRCH_MIN && wv[9:0] <= SRCH_MAX && wv[31:10] == '0;
        A_SPEED:
          // [R10] Only three rates exist.
          ok = (wv[1:0] == SPD_10M || wv[1:0] == SPD_2M || wv[1:0] == SPD_4M) &&
               wv[31:2] == '0;
        A_MAXSTA:
          // [R11] Limit above station.
          ok = sta_limit(wv[1:0]) > q.cfg.station && wv[31:2] == '0;
        A_RELAY1, A_RELAY2:
          // [R13] Range bounds check.
          ok = rng_ok(wv[15:0]) && wv[31:16] == '0;
        A_IRQ_EN: n.irq_en = wv[NST-1:0];
        A_IRQ_CLR: clr = wv[NST-1:0];
        default: ok = 1'b0;
      endcase
      // [R18] Rejected write keeps value.
      if (ok)
      begin
        case (q.aw_addr)
          A_STATION: n.cfg.station = wv[6:0];
          A_NETWORK: n.cfg.network = wv[7:0];
          A_CYC_TGT: n.cfg.cyc_tgt = wv[6:0];
          A_RESP_MON: n.cfg.resp_mon = wv[7:0];
          A_SRCH_INT: n.cfg.srch_int = wv[9:0];
          A_SPEED: n.cfg.speed = wv[1:0];
          A_MAXSTA: n.cfg.maxsta = wv[1:0];
          A_RELAY1: {n.cfg.r1hi, n.cfg.r1lo} = wv[15:0];
          A_RELAY2: {n.cfg.r2hi, n.cfg.r2lo} = wv[15:0];
          default: n.cfg = n.cfg;
        endcase
        n.bresp = RESP_OKAY;
      end
      else if (rv[32])
      begin
        ev[ST_REJECT] = 1'b1;
        n.bresp = RESP_SLVERR;
      end
      else
        n.bresp = RESP_DECERR;
      n.bvalid = 1'b1;
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;

    if (q.rvalid && rready)
      n.rvalid = 1'b0;
    if (arvalid && q.arready)
    begin
      rv = reg_rd(q, araddr);
      n.rdata = rv[31:0];
      n.rresp = rv[32] ? RESP_OKAY : RESP_DECERR;
      n.rvalid = 1'b1;
    end
    n.arready = !n.rvalid;

    // The measured cycle runs from one token arrival to the next and saturates.
    if (link_i.token_arrive)
    begin
      n.cyc_cur = q.cyc_run;
      n.cyc_run = '0;
    end
    else if (ms && q.cyc_run != 16'hFFFF)
      n.cyc_run = q.cyc_run + 1'b1;

    case (q.tst)
      T_IDLE:
        if (link_i.token_arrive)
        begin
          // [R4] [R6] Window from target.
          n.msg_ok = {9'h000, q.cfg.cyc_tgt} > q.cyc_run;
          n.hold_left = n.msg_ok ? q.cfg.cyc_tgt - q.cyc_run[6:0] : 7'h00;
          n.tst = T_HOLD;
          // [R9] Count token receptions.
          if (q.tok_cnt + 10'h001 >= q.cfg.srch_int)
          begin
            n.tok_cnt = '0;
            n.lo.search_start = 1'b1;
            ev[ST_SEARCH] = 1'b1;
          end
          else
            n.tok_cnt = q.tok_cnt + 10'h001;
        end
      T_HOLD:
      begin
        // [R6] Messages only within window.
        active = link_i.link_pending || (link_i.msg_pending && q.msg_ok);
        // [R5] [R4] Pass when idle or expired.
        pass = !active || (q.msg_ok && q.hold_left == 7'h00);
        if (ms && q.hold_left != 7'h00)
          n.hold_left = q.hold_left - 7'h01;
        if (pass)
        begin
          n.tst = T_IDLE;
          n.lo.token_pass = 1'b1;
        end
      end
      default: n.tst = T_IDLE;
    endcase
    n.lo.send_link = n.tst == T_HOLD && !pass && link_i.link_pending;
    n.lo.send_msg = n.tst == T_HOLD && !pass && link_i.msg_pending && n.msg_ok;

    // [R8] Limit is setting times two seconds.
    limit = RM_W'(q.cfg.resp_mon * RESP_UNIT_MS);
    case (q.rst)
      R_IDLE:
        if (link_i.cmd_sent)
        begin
          n.rst = R_WAIT;
          n.resp_ms = '0;
        end
      R_WAIT, R_RETRY:
        if (link_i.reply_rx)
          n.rst = R_IDLE;
        // [R7] Zero setting never times out.
        else if (q.cfg.resp_mon != 8'h00 && ms)
        begin
          n.resp_ms = q.resp_ms + 1'b1;
          // [R8] One resend, then fail.
          if (q.resp_ms + 1'b1 >= limit)
          begin
            n.resp_ms = '0;
            if (q.rst == R_WAIT)
            begin
              n.rst = R_RETRY;
              n.lo.cmd_resend = 1'b1;
              ev[ST_TIMEOUT] = 1'b1;
            end
            else
            begin
              n.rst = R_IDLE;
              ev[ST_FAIL] = 1'b1;
            end
          end
        end
      default: n.rst = R_IDLE;
    endcase

    if (link_i.relay_req)
    begin
      // [R12] [R13] [R14] Relay destination filter.
      hit = q.cfg.relay_en &&
            (in_rng(link_i.relay_net, q.cfg.r1lo, q.cfg.r1hi) ||
             in_rng(link_i.relay_net, q.cfg.r2lo, q.cfg.r2hi));
      n.lo.relay_fwd = hit;
      n.lo.relay_drop = !hit;
      ev[ST_RELAY] = hit;
    end

    // A flag raised in the clearing cycle survives the clear.
    n.status = (q.status & ~clr) | ev;
    n.irq = |(n.status & n.irq_en);
    // [R10] Drive selected rate.
    n.lo.speed = n.cfg.speed;
    n.lo.max_stations = sta_limit(n.cfg.maxsta);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.cfg <= CFG_DEF;
      q.tst <= T_IDLE;
      q.rst <= R_IDLE;
      q.lo.speed <= CFG_DEF.speed;
      q.lo.max_stations <= STA_MAX;
    end
    else
      q <= n;
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign bresp = q.bresp;
  assign bvalid = q.bvalid;
  assign arready = q.arready;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign rvalid = q.rvalid;
  assign link_o = q.lo;
  assign irq = q.irq;

endmodule
`default_nettype wire

// ===== tlc_link_cfg_assertions.sv
// Concurrent checks on the ports of the token link configuration block.
`default_nettype none
module tlc_link_cfg_chk
  import tlc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire tlc_link_in_t link_i,
  input wire tlc_link_out_t link_o
);
  logic quiet;
  assign quiet = !link_i.link_pending && !link_i.msg_pending;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_pass_empty: assert property (
    link_i.token_arrive && quiet ##1 quiet |-> ##[0:1] link_o.token_pass)
    else $error("token kept with nothing queued");
  a_search_cause: assert property (link_o.search_start |-> $past(link_i.token_arrive))
    else $error("search without a token");
  a_speed_code: assert property (link_o.speed != 2'h3)
    else $error("illegal speed code");
  a_limit_set: assert property (link_o.max_stations inside {7'h10, 7'h20, 7'h30, 7'h40})
    else $error("illegal station limit");
  a_relay_answer: assert property (
    link_i.relay_req |=> link_o.relay_fwd ^ link_o.relay_drop)
    else $error("relay request not answered");
  a_resend_once: assert property (link_o.cmd_resend |=> !link_o.cmd_resend [*8])
    else $error("repeated resend");
  a_clear_pulse: assert property (link_o.assign_clear |=> !link_o.assign_clear)
    else $error("assignment clear too long");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write not answered");
  a_decerr_zero: assert property (rvalid && rresp == RESP_DECERR |-> rdata == 32'h0)
    else $error("unmapped read data not zero");
  c_pass: cover property (link_o.token_pass);
  c_resend: cover property (link_o.cmd_resend);
  c_relay: cover property (link_o.relay_fwd);
endmodule
bind tlc_link_cfg tlc_link_cfg_chk chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .awvalid(awvalid),
  .awready(awready),
  .wvalid(wvalid),
  .wready(wready),
  .bvalid(bvalid),
  .arvalid(arvalid),
  .arready(arready),
  .rdata(rdata),
  .rresp(rresp),
  .rvalid(rvalid),
  .link_i(link_i),
  .link_o(link_o)
);
`default_nettype wire

// ===== tlc_link_cfg_tb.sv
// Self-checking bench for the token link configuration block.
`default_nettype none
module tlc_link_cfg_tb
  import tlc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r;
  tlc_link_in_t link_i;
  tlc_link_out_t link_o;
  int miscompares = 0, comparisons = 0, tmo = 0, n, i;
  logic [31:0] sh [16];
  logic [21:0] tab [21] = '{{8'h04, 12'h000, 2'h2}, {8'h04, 12'h041, 2'h2},
    {8'h04, 12'h03F, 2'h0}, {8'h08, 12'h000, 2'h2}, {8'h08, 12'h0FF, 2'h2},
    {8'h08, 12'h0FE, 2'h0}, {8'h0C, 12'h000, 2'h2}, {8'h0C, 12'h065, 2'h2},
    {8'h0C, 12'h001, 2'h0}, {8'h14, 12'h004, 2'h2}, {8'h14, 12'h3E9, 2'h2},
    {8'h14, 12'h3E8, 2'h0}, {8'h18, 12'h003, 2'h2}, {8'h18, 12'h001, 2'h0},
    {8'h18, 12'h002, 2'h0}, {8'h1C, 12'h002, 2'h2}, {8'h04, 12'h014, 2'h0},
    {8'h1C, 12'h001, 2'h0}, {8'h1C, 12'h000, 2'h2}, {8'h10, 12'h0FF, 2'h0},
    {8'h14, 12'h005, 2'h0}};
  logic [7:0] nets [6] = '{8'h05, 8'h0A, 8'h0B, 8'hC8, 8'h04, 8'hC9};
  int fw [6] = '{1, 1, 0, 1, 0, 0};
  always #25 aclk = ~aclk;
  // One interface, unique circuit number.
  // A 4-clock millisecond keeps the two-second response timeout short.
  tlc_link_cfg #(.TICK_CYCLES(4)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .link_i(link_i), .link_o(link_o), .irq(irq));
  tlc_link_peer peer (.aclk(aclk), .link_o(link_o), .link_i(link_i));
  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1);
    rs = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1);
    v = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd(a, d, r);
    chk("rresp", RESP_OKAY, r);
    chk("rdata", e, d & m);
  endtask
  task automatic wchk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    wr(a, v, r);
    chk("bresp", er, r);
    if (er === RESP_OKAY)
      sh[a[5:2]] = v;
    rchk(a, sh[a[5:2]], 32'hFFFFFFFF);
  endtask
  task automatic defaults;
    sh = '{default: 32'h0};
    sh[3] = 32'h64;
    sh[5] = 32'hA;
    sh[7] = 32'h3;
    for (int k = 1; k < 10; k++)
      rchk(8'(k * 4), sh[k], 32'hFFFFFFFF);
  endtask
  task automatic wait_pass;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (link_o.token_pass !== 1'h1 && n < 200);
  endtask
  task automatic rly(input logic [7:0] net, input int f);
    int f0, d0;
    f0 = peer.n_fwd;
    d0 = peer.n_drop;
    peer.relay(net);
    repeat (3) @(posedge aclk);
    chk("relay fwd", f, peer.n_fwd - f0);
    chk("relay answers", 1, peer.n_fwd + peer.n_drop - f0 - d0);
  endtask
  always @(posedge aclk)
  begin
    tmo <= tmo + 1;
    if (tmo == 40000)
    begin
      miscompares++;
      complete_run;
    end
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    defaults;
    chk("limit", 32'h40, link_o.max_stations);
    wchk(8'h14, 32'h5, RESP_OKAY);
    for (i = 0; i < 10; i++)
    begin
      peer.token(0, 1'h0, 1'h0);
      wait_pass;
      chk("pass delay", 2, n);
    end
    chk("searches", 2, peer.n_srch);
    wchk(8'h0C, 32'h4, RESP_OKAY);
    peer.token(0, 1'h0, 1'h0);
    wait_pass;
    // Five clocks between tokens always span exactly one tick, so the measured cycle is 1.
    peer.token(5, 1'h1, 1'h1);
    repeat (2) @(posedge aclk);
    chk("message send", 1, link_o.send_msg);
    wait_pass;
    chk("hold window", 1, n > 5 && n < 17);
    rchk(8'h34, 32'h1, 32'hFFFFFFFF);
    wchk(8'h0C, 32'h1, RESP_OKAY);
    peer.token(0, 1'h1, 1'h1);
    repeat (2) @(posedge aclk);
    chk("link only", 32'h1, {link_o.send_msg, link_o.send_link});
    peer.idle;
    wait_pass;
    chk("pass", 1, link_o.token_pass);
    for (i = 0; i < 21; i++)
      wchk(tab[i][21:14], 32'(tab[i][13:2]), tab[i][1:0]);
    chk("speed", 32'h2, link_o.speed);
    chk("limit", 32'h20, link_o.max_stations);
    wr(8'h38, 32'h1, r);
    chk("unmapped", RESP_DECERR, r);
    rd(8'h38, d, r);
    chk("unmapped", RESP_DECERR, r);
    rchk(8'h28, 32'h1, 32'h1);
    wchk(8'h2C, 32'h1, RESP_OKAY);
    chk("irq on", 1, irq);
    wchk(8'h2C, 32'h0, RESP_OKAY);
    chk("irq masked", 0, irq);
    wchk(8'h2C, 32'h1, RESP_OKAY);
    wr(8'h30, 32'h1, r);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 0, irq);
    rchk(8'h28, 32'h0, 32'h1);
    rly(8'h05, 0);
    wr(8'h00, 32'h2, r);
    rchk(8'h00, 32'h2, 32'hFFFFFFFF);
    rly(8'h05, 0);
    wchk(8'h20, 32'h0A05, RESP_OKAY);
    wchk(8'h24, 32'hC8C8, RESP_OKAY);
    wchk(8'h24, 32'h0506, RESP_SLVERR);
    for (i = 0; i < 6; i++)
      rly(nets[i], fw[i]);
    // Only the upper byte lane is written, so the lower range bound must survive.
    wstrb <= 4'h2;
    wr(8'h20, 32'h0000_0B00, r);
    wstrb <= 4'hF;
    chk("bresp", RESP_OKAY, r);
    rchk(8'h20, 32'h0B05, 32'hFFFFFFFF);
    wchk(8'h10, 32'h0, RESP_OKAY);
    peer.cmd(1'h0);
    repeat (8100) @(posedge aclk);
    chk("no resend", 0, peer.n_res);
    peer.cmd(1'h1);
    wchk(8'h10, 32'h1, RESP_OKAY);
    peer.cmd(1'h0);
    n = 0;
    while (peer.n_res == 0 && n < 9000)
    begin
      @(posedge aclk);
      n++;
    end
    chk("resend time", 1, n > 7990 && n < 8010);
    repeat (8100) @(posedge aclk);
    chk("resends", 1, peer.n_res);
    rchk(8'h28, 32'h6, 32'h6);
    wr(8'h00, 32'h1, r);
    repeat (3) @(posedge aclk);
    chk("assign clear", 1, peer.n_clr);
    defaults;
    chk("speed", 0, link_o.speed);
    rly(8'h05, 0);
    complete_run;
  end
endmodule
`default_nettype wire

// ===== tlc_link_peer.sv
// Model of the other stations that share the token link.
`default_nettype none
module tlc_link_peer
  import tlc_pkg::*;
(
  input wire logic aclk,
  input wire tlc_link_out_t link_o,
  output tlc_link_in_t link_i
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc = 0, last = 0, n_srch = 0, n_res = 0, n_fwd = 0, n_drop = 0, n_clr = 0;
  initial link_i = '0;
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    n_srch <= n_srch + int'(link_o.search_start);
    n_res <= n_res + int'(link_o.cmd_resend);
    n_fwd <= n_fwd + int'(link_o.relay_fwd);
    n_drop <= n_drop + int'(link_o.relay_drop);
    n_clr <= n_clr + int'(link_o.assign_clear);
  end
  task automatic token(input int gap, input logic lp, input logic mp);
    while (cyc < last + gap)
      @(posedge aclk);
    link_i.token_arrive <= 1'h1;
    link_i.link_pending <= lp;
    link_i.msg_pending <= mp;
    last = cyc;
    @(posedge aclk);
    link_i.token_arrive <= 1'h0;
  endtask
  task automatic idle;
    @(posedge aclk);
    link_i.link_pending <= 1'h0;
    link_i.msg_pending <= 1'h0;
  endtask
  task automatic cmd(input logic rep);
    @(posedge aclk);
    link_i.cmd_sent <= ~rep;
    link_i.reply_rx <= rep;
    @(posedge aclk);
    link_i.cmd_sent <= 1'h0;
    link_i.reply_rx <= 1'h0;
  endtask
  task automatic relay(input logic [7:0] net);
    @(posedge aclk);
    link_i.relay_req <= 1'h1;
    link_i.relay_net <= net;
    @(posedge aclk);
    link_i.relay_req <= 1'h0;
    // A released net number is inverted so a stale value never matches.
    link_i.relay_net <= ~net;
  endtask
endmodule
`default_nettype wire

// ===== tlc_pkg.sv
// Constants and types shared by the token link configuration block.
`default_nettype none
package tlc_pkg;
  localparam int AW = 8;
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_STATION = 8'h04;
  localparam logic [AW-1:0] A_NETWORK = 8'h08;
  localparam logic [AW-1:0] A_CYC_TGT = 8'h0C;
  localparam logic [AW-1:0] A_RESP_MON = 8'h10;
  localparam logic [AW-1:0] A_SRCH_INT = 8'h14;
  localparam logic [AW-1:0] A_SPEED = 8'h18;
  localparam logic [AW-1:0] A_MAXSTA = 8'h1C;
  localparam logic [AW-1:0] A_RELAY1 = 8'h20;
  localparam logic [AW-1:0] A_RELAY2 = 8'h24;
  localparam logic [AW-1:0] A_STATUS = 8'h28;
  localparam logic [AW-1:0] A_IRQ_EN = 8'h2C;
  localparam logic [AW-1:0] A_IRQ_CLR = 8'h30;
  localparam logic [AW-1:0] A_CYC_CUR = 8'h34;
  localparam int CTRL_RESTORE = 0;
  localparam int CTRL_RELAY = 1;
  localparam int RLY_HI_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int NST = 5;
  localparam int ST_REJECT = 0;
  localparam int ST_TIMEOUT = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_SEARCH = 3;
  localparam int ST_RELAY = 4;
  localparam logic [6:0] STA_MIN = 7'h01;
  localparam logic [6:0] STA_MAX = 7'h40;
  localparam logic [6:0] STA_STEP = 7'h10;
  localparam logic [7:0] NET_MIN = 8'h01;
  localparam logic [7:0] NET_MAX = 8'hFE;
  localparam logic [6:0] CYC_MIN = 7'h01;
  localparam logic [6:0] CYC_MAX = 7'h64;
  localparam logic [9:0] SRCH_MIN = 10'h005;
  localparam logic [9:0] SRCH_MAX = 10'h3E8;
  localparam logic [1:0] SPD_10M = 2'h0;
  localparam logic [1:0] SPD_2M = 2'h1;
  localparam logic [1:0] SPD_4M = 2'h2;
  localparam int MS_NS = 1000000;
  localparam int CLK_NS = 50;
  localparam int RESP_UNIT_MS = 2000;
  localparam int TICK_W = 20;
  localparam int RM_W = 19;

  typedef struct packed {
    logic [6:0] station;
    logic [7:0] network;
    logic [6:0] cyc_tgt;
    logic [7:0] resp_mon;
    logic [9:0] srch_int;
    logic [1:0] speed;
    logic [1:0] maxsta;
    logic relay_en;
    logic [7:0] r1lo;
    logic [7:0] r1hi;
    logic [7:0] r2lo;
    logic [7:0] r2hi;
  } tlc_cfg_t;

  localparam tlc_cfg_t CFG_DEF = '{station: 7'h00, network: 8'h00, cyc_tgt: 7'h64,
    resp_mon: 8'h00, srch_int: 10'h00A, speed: SPD_10M, maxsta: 2'h3, relay_en: 1'b0,
    r1lo: 8'h00, r1hi: 8'h00, r2lo: 8'h00, r2hi: 8'h00};

  typedef struct packed {
    logic token_arrive;
    logic link_pending;
    logic msg_pending;
    logic cmd_sent;
    logic reply_rx;
    logic relay_req;
    logic [7:0] relay_net;
  } tlc_link_in_t;

  typedef struct packed {
    logic token_pass;
    logic send_link;
    logic send_msg;
    logic cmd_resend;
    logic search_start;
    logic relay_fwd;
    logic relay_drop;
    logic assign_clear;
    logic [1:0] speed;
    logic [6:0] max_stations;
  } tlc_link_out_t;
endpackage
`default_nettype wire
